// ===== rtl/tca_front.sv
// Purpose: Activation capture, priority, vector and information fetch for the transfer controller
// Assumes: Source requests are synchronous one-cycle pulses; memory port answers with rd_ack
// Notes:   Data path of the transfer engine sits outside; it reports xfer_done and count_zero
`timescale 1ns/1ps
`include "tca_map.svh"

// Overview of operation
// - Activation from sources or software write
// - Enable bit steers source to engine or CPU
// - Select bit: interrupt each transfer or at end
// - Passing interrupt clears source enable bit
// - Software interrupt each transfer or at end
// - Software enable clears unless interrupt raised
// - Simultaneous requests served by fixed priority
// - Each source owns a 2-byte vector entry
// - Software vector is 0x0400 plus field
// - Read vector first, then transfer information
// - Hardware vectors consecutive from 0x400 to 0x440
// - Software request uses its entry, lowest rank
// - Engine excludes itself and other DMA controller
// - Vector field writable only when enable clear
// - No new transfer while nonmaskable flag set
// - Base register forms upper 16 address bits
module tca_front
  import tca_pkg::*;
#(
  parameter int NUM_SRC = `TCA_NUM_HW_SRC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [NUM_SRC-1:0]  src_irq,
  input  wire logic [NUM_SRC-1:0]  en_wr_mask,
  input  wire logic [NUM_SRC-1:0]  en_wr_data,
  output logic      [NUM_SRC-1:0]  activation_enable_regs,
  input  wire logic                csr_wr,
  input  wire logic                csr_wr_enable,
  input  wire logic [7:0]          csr_wr_vector,
  output logic                     soft_activation_enable,
  output logic      [7:0]          soft_vector_field,
  input  wire logic                irq_every_transfer_select,
  input  wire logic                nonmaskable_irq_flag,
  input  wire logic [15:0]         info_base_upper,
  output logic      [NUM_SRC-1:0]  cpu_irq,
  output logic                     soft_activation_irq,
  output logic                     rd_req,
  output logic      [31:0]         rd_addr,
  input  wire logic                rd_ack,
  input  wire logic [15:0]         rd_data,
  output logic                     info_valid,
  output logic      [31:0]         info_addr,
  output logic                     busy,
  output logic      [5:0]          active_src,
  input  wire logic                xfer_done,
  input  wire logic                count_zero
);

  // Refuse source counts the index encoding cannot serve
  if (NUM_SRC < 1 || NUM_SRC > `TCA_NUM_HW_SRC) begin : g_bad_num_src
    $error("NUM_SRC out of range");
  end

  function automatic logic [15:0] vec_of(input logic [5:0] idx, input logic [7:0] sw);
    if (idx == `TCA_SW_IDX) begin
      vec_of = `TCA_VEC_BASE + {8'h00, sw};
    end else begin
      vec_of = `TCA_VEC_BASE + 16'({idx, 1'b0});
    end
  endfunction

  tca_state_e            state_q;
  logic [NUM_SRC-1:0]    pend_q;
  logic                  sw_pend_q;
  logic [5:0]            act_q;
  logic [15:0]           start_q;
  logic [NUM_SRC-1:0]    cpu_irq_q;
  logic                  sw_irq_q;
  logic                  rd_req_q;
  logic [31:0]           rd_addr_q;
  logic                  info_valid_q;
  logic                  soft_activation_enable_d;

  // Requests steered to engine or passed to CPU
  wire  [NUM_SRC-1:0]    to_engine = src_irq & activation_enable_regs;
  wire  [NUM_SRC-1:0]    to_cpu    = src_irq & ~activation_enable_regs;
  wire  [NUM_SRC-1:0]    avail     = pend_q | to_engine;
  wire  [NUM_SRC-1:0]    win_oh    = avail & (~avail + NUM_SRC'(1));
  wire                   hw_any    = |avail;
  wire                   sw_any    = sw_pend_q | (csr_wr & csr_wr_enable);
  wire                   can_start = (state_q == TCA_IDLE) && !nonmaskable_irq_flag;
  wire                   take_hw   = can_start && hw_any;
  wire                   take_sw   = can_start && !hw_any && sw_any;
  wire                   done      = (state_q == TCA_XFER) && xfer_done;
  wire                   raise     = irq_every_transfer_select || count_zero;
  wire                   is_sw     = act_q == `TCA_SW_IDX;
  wire                   vec_wr_ok = csr_wr && !soft_activation_enable;
  // Field being written counts for a request taken in the same cycle
  wire  [7:0]            sw_vec    = vec_wr_ok ? csr_wr_vector : soft_vector_field;

  logic [5:0] win_idx;
  always_comb begin
    win_idx = 6'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (win_oh[i]) begin
        win_idx = 6'(i);
      end
    end
  end

  wire  [5:0]            next_act  = take_hw ? win_idx : `TCA_SW_IDX;
  wire  [NUM_SRC-1:0]    hw_clr    = (done && raise && !is_sw) ? (NUM_SRC'(1) << act_q) : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      activation_enable_regs <= '0;
    end else begin
      activation_enable_regs <= ((activation_enable_regs & ~en_wr_mask) | (en_wr_data & en_wr_mask))
                                & ~hw_clr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= '0;
    end else begin
      pend_q <= avail & ~(take_hw ? win_oh : '0);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sw_pend_q <= 1'b0;
    end else begin
      sw_pend_q <= sw_any && !take_sw && soft_activation_enable_d;
    end
  end

  always_comb begin
    soft_activation_enable_d = soft_activation_enable;
    if (csr_wr) begin
      soft_activation_enable_d = csr_wr_enable;
    end
    if (done && is_sw && !raise) begin
      soft_activation_enable_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      soft_activation_enable <= 1'b0;
      soft_vector_field      <= 8'h00;
    end else begin
      soft_activation_enable <= soft_activation_enable_d;
      if (vec_wr_ok) begin
        soft_vector_field <= csr_wr_vector;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q      <= TCA_IDLE;
      act_q        <= 6'h00;
      start_q      <= 16'h0000;
      rd_req_q     <= 1'b0;
      rd_addr_q    <= 32'h0000_0000;
      info_valid_q <= 1'b0;
    end else begin
      info_valid_q <= 1'b0;
      unique case (state_q)
        TCA_IDLE: begin
          if (take_hw || take_sw) begin
            act_q     <= next_act;
            rd_req_q  <= 1'b1;
            rd_addr_q <= {16'h0000, vec_of(next_act, sw_vec)};
            state_q   <= TCA_VEC;
          end
        end
        TCA_VEC: begin
          if (rd_ack) begin
            start_q   <= rd_data & `TCA_ALIGN_MASK;
            rd_addr_q <= {info_base_upper, rd_data & `TCA_ALIGN_MASK};
            state_q   <= TCA_INFO;
          end
        end
        TCA_INFO: begin
          if (rd_ack) begin
            rd_req_q     <= 1'b0;
            info_valid_q <= 1'b1;
            state_q      <= TCA_XFER;
          end
        end
        TCA_XFER: begin
          if (xfer_done) begin
            state_q <= TCA_DONE;
          end
        end
        TCA_DONE: begin
          state_q <= TCA_IDLE;
        end
        default: begin
          state_q <= TCA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_irq_q <= '0;
      sw_irq_q  <= 1'b0;
    end else begin
      cpu_irq_q <= to_cpu | hw_clr;
      sw_irq_q  <= done && is_sw && raise;
    end
  end

  assign cpu_irq             = cpu_irq_q;
  assign soft_activation_irq = sw_irq_q;
  assign rd_req              = rd_req_q;
  assign rd_addr             = rd_addr_q;
  assign info_valid          = info_valid_q;
  assign info_addr           = {info_base_upper, start_q};
  assign busy                = state_q != TCA_IDLE;
  assign active_src          = act_q;

endmodule // tca_front

// ===== rtl/tca_map.svh
// Purpose: Constants for the transfer controller activation and vector front end
// Assumes: 33 hardware sources, 2-byte vector entries
// Notes:   Offsets are byte addresses
`ifndef TCA_MAP_SVH
`define TCA_MAP_SVH
`define TCA_NUM_HW_SRC     33
`define TCA_VEC_BASE       16'h0400
`define TCA_VEC_STRIDE     16'h0002
`define TCA_VEC_LAST       16'h0440
`define TCA_ENTRY_BYTES    2
`define TCA_ALIGN_MASK     16'hFFFC
`define TCA_SW_IDX         6'h21
`endif

// ===== rtl/tca_pkg.sv
// Purpose: Types for the transfer controller activation front end
// Assumes: Constants live in tca_map.svh
// Notes:   Binary state codes
package tca_pkg;
  typedef enum logic [2:0] {
    TCA_IDLE   = 3'b000,
    TCA_VEC    = 3'b001,
    TCA_INFO   = 3'b010,
    TCA_XFER   = 3'b011,
    TCA_DONE   = 3'b100
  } tca_state_e;
endpackage

// ===== test/tca_front_props.sv
// Purpose: Port assertions for tca_front
// Assumes: One clock, sync reset
// Notes:   Bound from tb_top
`timescale 1ns/1ps
module tca_front_props #(
  parameter int NUM_SRC = 33
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [NUM_SRC-1:0] src_irq,
  input wire logic [NUM_SRC-1:0] activation_enable_regs,
  input wire logic               soft_activation_enable,
  input wire logic [7:0]         soft_vector_field,
  input wire logic               nonmaskable_irq_flag,
  input wire logic [15:0]        info_base_upper,
  input wire logic [NUM_SRC-1:0] cpu_irq,
  input wire logic               soft_activation_irq,
  input wire logic               rd_req,
  input wire logic [31:0]        rd_addr,
  input wire logic               rd_ack,
  input wire logic               info_valid,
  input wire logic [31:0]        info_addr,
  input wire logic               busy,
  input wire logic [5:0]         active_src
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [NUM_SRC-1:0] pass_q;
  always_ff @(posedge clk) pass_q <= rst ? '0 : src_irq & ~activation_enable_regs;
  a_hw_vec_addr: assert property ($rose(rd_req) && active_src < 6'd33 |->
    rd_addr == 32'h0000_0400 + {active_src, 1'b0}) else $error("bad source vector");
  a_sw_vec_addr: assert property ($rose(rd_req) && active_src == 6'd33 |->
    rd_addr == 32'h0000_0400 + soft_vector_field) else $error("bad soft vector");
  a_nmi_no_start: assert property (!busy && nonmaskable_irq_flag |=> !rd_req) else $error("start under nmi");
  a_info_addr: assert property (info_valid |-> info_addr[31:16] == info_base_upper &&
    info_addr[1:0] == 2'b00) else $error("bad info address");
  a_irq_clears_en: assert property (|cpu_irq |-> (cpu_irq & activation_enable_regs) == '0) else $error("enable kept");
  a_pass_to_cpu: assert property (|pass_q |-> (cpu_irq & pass_q) == pass_q) else $error("irq not passed");
  a_sw_irq_keeps: assert property (soft_activation_irq |-> soft_activation_enable) else $error("soft enable lost");
  a_info_after_ack: assert property ($rose(info_valid) |-> $past(rd_ack)) else $error("info without read");
endmodule // tca_front_props

// ===== test/tca_mem_model.sv
// Purpose: Memory answering vector and information reads
// Assumes: Read held until acknowledged
// Notes:   Delay from lat; data toggles between answers
`timescale 1ns/1ps
module tca_mem_model (
  input  wire logic        clk,
  input  wire logic        rd_req,
  input  wire logic [31:0] rd_addr,
  input  wire logic [1:0]  lat,
  output logic             rd_ack,
  output logic      [15:0] rd_data
);
  logic [1:0] cnt_q = 2'b00;
  initial rd_ack = 1'b0;
  initial rd_data = 16'h0000;
  always @(posedge clk) begin
    rd_ack <= 1'b0;
    rd_data <= ~rd_data;
    cnt_q <= 2'b00;
    if (rd_req && !rd_ack && cnt_q == lat) begin
      rd_ack <= 1'b1;
      rd_data <= {rd_addr[13:0], 2'b00};
    end else if (rd_req && !rd_ack) cnt_q <= cnt_q + 2'd1;
  end
endmodule // tca_mem_model

// ===== test/tb_top.sv
// Purpose: Self-checking bench for tca_front
// Assumes: Inputs change on falling edge
// Notes:   Memory from tca_mem_model
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, csr_wr = 1'b0, csr_wr_enable = 1'b0, xfer_done = 1'b0;
  logic        irq_every_transfer_select = 1'b0, nonmaskable_irq_flag = 1'b0, count_zero = 1'b0;
  logic        soft_activation_enable, soft_activation_irq, rd_req, rd_ack, info_valid, busy;
  logic [32:0] src_irq = '0, en_wr_mask = '0, en_wr_data = '0, activation_enable_regs, cpu_irq;
  logic [7:0]  csr_wr_vector = 8'h00, soft_vector_field;
  logic [15:0] info_base_upper = 16'hA5C3, rd_data;
  logic [31:0] rd_addr, info_addr;
  logic [5:0]  active_src;
  logic [1:0]  lat = 2'd3;
  int          mismatches = 0, compares = 0;
  always #25 clk = ~clk;
  tca_front i_dut (.clk, .rst, .src_irq, .en_wr_mask, .en_wr_data, .activation_enable_regs, .csr_wr,
    .csr_wr_enable, .csr_wr_vector, .soft_activation_enable, .soft_vector_field, .irq_every_transfer_select,
    .nonmaskable_irq_flag, .info_base_upper, .cpu_irq, .soft_activation_irq, .rd_req, .rd_addr, .rd_ack,
    .rd_data, .info_valid, .info_addr, .busy, .active_src, .xfer_done, .count_zero);
  tca_mem_model i_mem (.clk, .rd_req, .rd_addr, .lat, .rd_ack, .rd_data);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic serve(input int idx, input logic [31:0] va, input logic sel, cz, ex);
    int n;
    for (n = 0; n < 40 && rd_req !== 1'b1; n++) @(negedge clk);
    chk(busy, 1'b1);
    chk(rd_addr, va);
    chk(active_src, idx[5:0]);
    for (n = 0; n < 40 && info_valid !== 1'b1; n++) @(negedge clk);
    chk(info_valid, 1'b1);
    chk(info_addr, {info_base_upper, va[13:0], 2'b00});
    irq_every_transfer_select = sel;
    count_zero = cz;
    xfer_done = 1'b1;
    @(negedge clk);
    xfer_done = 1'b0;
    chk(idx == 33 ? soft_activation_irq : cpu_irq[idx], ex);
    for (n = 0; n < 9 && busy !== 1'b0; n++) @(negedge clk);
    chk(busy, 1'b0);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    src_irq[5] = 1'b1;
    @(negedge clk);
    src_irq = '0;
    chk(cpu_irq[5], 1'b1);
    en_wr_mask = 33'h1_0000_0008;
    en_wr_data = 33'h1_0000_0008;
    @(negedge clk);
    en_wr_mask = '0;
    nonmaskable_irq_flag = 1'b1;
    csr_wr = 1'b1;
    csr_wr_enable = 1'b1;
    csr_wr_vector = 8'h10;
    src_irq = 33'h1_0000_0008;
    @(negedge clk);
    csr_wr = 1'b0;
    src_irq = '0;
    repeat (4) @(negedge clk);
    chk(rd_req, 1'b0);
    nonmaskable_irq_flag = 1'b0;
    serve(3, 32'h0000_0406, 1'b1, 1'b0, 1'b1);
    chk(activation_enable_regs[3], 1'b0);
    lat = 2'd0;
    serve(32, 32'h0000_0440, 1'b0, 1'b0, 1'b0);
    chk(activation_enable_regs[32], 1'b1);
    serve(33, 32'h0000_0410, 1'b0, 1'b0, 1'b0);
    chk(soft_activation_enable, 1'b0);
    src_irq[32] = 1'b1;
    @(negedge clk);
    src_irq = '0;
    serve(32, 32'h0000_0440, 1'b0, 1'b1, 1'b1);
    chk(activation_enable_regs[32], 1'b0);
    csr_wr = 1'b1;
    csr_wr_vector = 8'h22;
    @(negedge clk);
    csr_wr = 1'b0;
    serve(33, 32'h0000_0422, 1'b1, 1'b0, 1'b1);
    chk(soft_activation_enable, 1'b1);
    csr_wr = 1'b1;
    csr_wr_vector = 8'h44;
    @(negedge clk);
    csr_wr = 1'b0;
    chk(soft_vector_field, 8'h22);
    tally_and_finish();
  end
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
endmodule // tb_top
bind tca_front tca_front_props #(.NUM_SRC(NUM_SRC)) i_props (.clk, .rst, .src_irq, .activation_enable_regs,
  .soft_activation_enable, .soft_vector_field, .nonmaskable_irq_flag, .info_base_upper, .cpu_irq,
  .soft_activation_irq, .rd_req, .rd_addr, .rd_ack, .info_valid, .info_addr, .busy, .active_src);
